// ==== bench/test_pmt_timer.sv ====
// Purpose: Self-checking bench of the period match timer over APB
// Assumes: pready answers in the access cycle; counter steps every 4 clocks times prescale
// Notes:   Intervals between time base pulses reveal prescale and period; no stimulus is random
`timescale 1ns/10ps
`include "pmt_params.svh"
module test_pmt_timer;
	import pmt_pkg::*;
	// Clock, reset and bus drive
	logic      clk          = 1'b0;
	logic      rst_n        = 1'b0;
	logic      psel         = 1'b0;
	logic      penable      = 1'b0;
	logic      pwrite       = 1'b0;
	pmt_addr_t paddr        = 12'h000;
	pmt_word_t pwdata       = 32'h0000_0000;
	// Observed outputs and bookkeeping
	pmt_word_t prdata;
	logic      pready;
	logic      pslverr;
	logic      irq;
	logic      pwm_time_base;
	pmt_word_t rd;
	logic      err;
	int        n;
	int        fail_count   = 0;
	int        total_checks = 0;

	pmt_timer i_pmt_timer (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq(irq), .pwm_time_base(pwm_time_base));

	// 20 MHz clock
	always #25 clk = ~clk;

	task report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : report_and_stop

	task chk(input string what, input pmt_word_t seen, input pmt_word_t exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// One APB transfer; read data and error are taken at the pready edge only
	task apb(input logic wr, input pmt_addr_t a, input pmt_word_t d);
		int k;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			chk("pready", 32'h0000_0000, 32'h0000_0001);
			report_and_stop();
		end
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Cycles until the next time base pulse, bounded
	task wait_pulse;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pwm_time_base !== 1'b1 && n < 2000);
		if (n >= 2000) begin
			chk("time base pulse", 32'h0000_0000, 32'h0000_0001);
			report_and_stop();
		end
	endtask : wait_pulse

	// Reset values of the whole map and an unmapped read
	task automatic t_reset;
		pmt_addr_t ofs [6] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h014};
		pmt_word_t val [6] = '{32'h0000_0000, 32'h0000_00FF, 32'h0000_0000, 32'h0000_0000,
			32'h0000_0000, 32'h0000_0000};
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, ofs[i], 32'h0000_0000);
			chk("reset value", rd, val[i]);
		end
		apb(1'b0, 12'h018, 32'h0000_0000);
		chk("unmapped error", {31'h0, err}, 32'h0000_0001);
		chk("unmapped data", rd, 32'h0000_0000);
		$display("t_reset done");
	endtask : t_reset

	// Read-write registers, control layout, stopped counter kept by control write
	task t_regs;
		apb(1'b1, `PMT_OFS_COUNT, 32'h0000_005A);
		apb(1'b0, `PMT_OFS_COUNT, 32'h0000_0000);
		chk("count", rd, 32'h0000_005A);
		apb(1'b1, `PMT_OFS_PERIOD, 32'h0000_00A5);
		apb(1'b0, `PMT_OFS_PERIOD, 32'h0000_0000);
		chk("period", rd, 32'h0000_00A5);
		apb(1'b1, `PMT_OFS_CONTROL, 32'h0000_00FB);
		apb(1'b0, `PMT_OFS_CONTROL, 32'h0000_0000);
		chk("control", rd, 32'h0000_007B);
		repeat (40) @(posedge clk);
		apb(1'b0, `PMT_OFS_COUNT, 32'h0000_0000);
		chk("count kept", rd, 32'h0000_005A);
		apb(1'b1, `PMT_OFS_COUNT, 32'h0000_0000);
		$display("t_regs done");
	endtask : t_regs

	// Pulse spacing for every prescale code and a second period
	task automatic t_prescale;
		pmt_word_t per [5] = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0001, 32'h0000_0001, 32'h0000_0003};
		logic [1:0] code [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0};
		int        exp  [5] = '{8, 32, 128, 128, 16};
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, `PMT_OFS_PERIOD, per[i]);
			apb(1'b1, `PMT_OFS_CONTROL, {29'h0, 1'b1, code[i]});
			wait_pulse();
			wait_pulse();
			chk("pulse spacing", pmt_word_t'(n), pmt_word_t'(exp[i]));
			@(posedge clk);
			chk("pulse width", {31'h0, pwm_time_base}, 32'h0000_0000);
		end
		$display("t_prescale done");
	endtask : t_prescale

	// Postscale at both end codes, flag latch, masking and clear
	task automatic t_post;
		logic [3:0] code [2] = '{4'h0, 4'hF};
		apb(1'b1, `PMT_OFS_PERIOD, 32'h0000_0001);
		apb(1'b1, `PMT_OFS_ENABLE, 32'h0000_0001);
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, `PMT_OFS_CONTROL, 32'h0000_0000);
			apb(1'b1, `PMT_OFS_CLEAR, 32'h0000_0001);
			apb(1'b1, `PMT_OFS_CONTROL, {25'h0, code[i], 1'b1, 2'h0});
			n = 0;
			for (int k = 0; k < 400 && irq !== 1'b1; k++) begin
				@(posedge clk);
				if (irq !== 1'b1 && pwm_time_base === 1'b1) n++;
			end
			chk("irq raised", {31'h0, irq}, 32'h0000_0001);
			chk("matches before flag", pmt_word_t'(n), pmt_word_t'(code[i]));
			apb(1'b0, `PMT_OFS_STATUS, 32'h0000_0000);
			chk("flag", rd, 32'h0000_0001);
		end
		apb(1'b1, `PMT_OFS_ENABLE, 32'h0000_0000);
		#1 chk("irq masked", {31'h0, irq}, 32'h0000_0000);
		apb(1'b0, `PMT_OFS_STATUS, 32'h0000_0000);
		chk("flag held", rd, 32'h0000_0001);
		apb(1'b1, `PMT_OFS_CONTROL, 32'h0000_0000);
		apb(1'b1, `PMT_OFS_CLEAR, 32'h0000_0001);
		apb(1'b0, `PMT_OFS_STATUS, 32'h0000_0000);
		chk("flag cleared", rd, 32'h0000_0000);
		apb(1'b1, `PMT_OFS_CONTROL, 32'h0000_0004);
		$display("t_post done");
	endtask : t_post

	// Main sequence; a second reset lands while the timer runs
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_regs();
		t_prescale();
		t_post();
		repeat (7) @(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		report_and_stop();
	end
endmodule : test_pmt_timer

// ==== include/pmt_div_if.sv ====
// Purpose: Carrier between the timer and one of its dividers
// Assumes: One clock domain
// Notes:   ctl side drives tick, clear and limit; div side answers
`timescale 1ns/10ps
interface pmt_div_if;
	logic       tick;
	logic       clr;
	logic [3:0] lim;
	logic       pulse;
	logic [3:0] cnt;
	modport ctl (output tick, output clr, output lim, input pulse, input cnt);
	modport div (input tick, input clr, input lim, output pulse, output cnt);
endinterface : pmt_div_if

// ==== include/pmt_params.svh ====
// Purpose: Offsets, field positions, reset values and counts of the period match timer
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Definitions only
`ifndef PMT_PARAMS_SVH
`define PMT_PARAMS_SVH

// Register byte offsets
`define PMT_OFS_COUNT     12'h000
`define PMT_OFS_PERIOD    12'h004
`define PMT_OFS_CONTROL   12'h008
`define PMT_OFS_STATUS    12'h00C
`define PMT_OFS_CLEAR     12'h010
`define PMT_OFS_ENABLE    12'h014

// Control field positions
`define PMT_CTL_POST_HI   6
`define PMT_CTL_POST_LO   3
`define PMT_CTL_RUN       2
`define PMT_CTL_PRE_HI    1
`define PMT_CTL_PRE_LO    0

// Reset values
`define PMT_COUNT_RST     8'h00
`define PMT_PERIOD_RST    8'hFF
`define PMT_CONTROL_RST   7'h00

// Divider limits, each one less than the ratio
`define PMT_INSTR_LIM     4'h3
`define PMT_PRE1_LIM      4'h0
`define PMT_PRE4_LIM      4'h3
`define PMT_PRE16_LIM     4'hF

`endif

// ==== include/pmt_pkg.sv ====
// Purpose: Types shared by the period match timer
// Assumes: Nothing beyond SystemVerilog
// Notes:   Constants live in pmt_params.svh
package pmt_pkg;
	typedef logic [31:0] pmt_word_t;
	typedef logic [7:0]  pmt_byte_t;
	typedef logic [11:0] pmt_addr_t;
endpackage : pmt_pkg

// ==== rtl/pmt_scaler.sv ====
// Purpose: Event divider, one pulse out per lim+1 ticks in
// Assumes: Tick is a one-cycle enable on clk
// Notes:   Clear wins over tick and suppresses the pulse of that cycle
`timescale 1ns/10ps
module pmt_scaler (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Divider channel
	pmt_div_if.div   dv
);
	import pmt_pkg::*;

	logic [3:0] count;
	logic [3:0] next_count;

	// Wrap at the limit so the ratio follows a live limit change
	assign next_count = (count >= dv.lim) ? 4'h0 : count + 4'h1;
	assign dv.pulse   = dv.tick && !dv.clr && (count >= dv.lim);
	assign dv.cnt     = count;

	// Count ticks; clear resets the phase
	always_ff @(posedge clk) begin
		if (!rst_n || dv.clr) begin
			count <= 4'h0;
		end else if (dv.tick) begin
			count <= next_count;
		end
	end
endmodule : pmt_scaler

// ==== rtl/pmt_timer.sv ====
// Purpose: 8-bit period match timer with prescaler, postscaler and APB registers
// Assumes: clk is the oscillator, 20 MHz; rst_n synchronous, active low
// Notes:   Counter steps on prescaled instruction ticks while running
// Behaviour
// - Tick counter readable and writable any time
// - Period register readable, writable, compared with counter
// - Counter clock is oscillator/4 through prescaler
// - Postscale divides matches by field plus one
// - Postscaled match sets flag until software clears
// - Any reset clears the tick counter
// - Counter or control write, reset clear scalers
// - Control write leaves counter value unchanged
// - Control bit layout; bit 7 reads zero
// - Period match drives PWM time base out
`timescale 1ns/10ps
`include "pmt_params.svh"
module pmt_timer (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire pmt_pkg::pmt_addr_t paddr,
	input  wire pmt_pkg::pmt_word_t pwdata,
	output pmt_pkg::pmt_word_t      prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Events
	output logic                   irq,
	output logic                   pwm_time_base
);
	import pmt_pkg::*;

	pmt_div_if instr_if ();
	pmt_div_if pre_if ();
	pmt_div_if post_if ();

	pmt_byte_t  tick_count;
	pmt_byte_t  period_value;
	logic [3:0] post_divide_select;
	logic       timer_run;
	logic [1:0] pre_divide_select;
	logic       match_flag;
	logic       irq_enable;
	pmt_byte_t  next_count;
	pmt_word_t  next_rdata;
	logic       bus_err;

	// APB decode
	wire setup_phase = psel && !penable;
	wire wr_access   = psel && penable && pwrite;
	wire hit_count   = (paddr == `PMT_OFS_COUNT);
	wire hit_period  = (paddr == `PMT_OFS_PERIOD);
	wire hit_control = (paddr == `PMT_OFS_CONTROL);
	wire hit_status  = (paddr == `PMT_OFS_STATUS);
	wire hit_clear   = (paddr == `PMT_OFS_CLEAR);
	wire hit_enable  = (paddr == `PMT_OFS_ENABLE);
	wire hit_any     = hit_count || hit_period || hit_control || hit_status || hit_clear || hit_enable;
	wire cnt_wr      = wr_access && hit_count;
	wire per_wr      = wr_access && hit_period;
	wire ctl_wr      = wr_access && hit_control;
	wire clr_wr      = wr_access && hit_clear && pwdata[0];
	wire ena_wr      = wr_access && hit_enable;

	// Control read image, top bit unimplemented
	wire [7:0] control_image = {1'b0, post_divide_select, timer_run, pre_divide_select};

	// Read mux; the clear register is write-only and reads zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (hit_count) begin
			next_rdata[7:0] = tick_count;
		end else if (hit_period) begin
			next_rdata[7:0] = period_value;
		end else if (hit_control) begin
			next_rdata[7:0] = control_image;
		end else if (hit_status) begin
			next_rdata[0] = match_flag;
		end else if (hit_enable) begin
			next_rdata[0] = irq_enable;
		end
	end

	// Zero wait states; unmapped addresses answer with an error
	assign pready  = 1'b1;
	assign pslverr = bus_err;

	// Read data and error captured in setup so they stand through access
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata  <= 32'h0000_0000;
			bus_err <= 1'b0;
		end else if (setup_phase) begin
			prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
			bus_err <= !hit_any;
		end
	end

	// Control, period and enable registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{post_divide_select, timer_run, pre_divide_select} <= `PMT_CONTROL_RST;
			irq_enable <= 1'b0;
			period_value <= `PMT_PERIOD_RST;
		end else begin
			if (ctl_wr) begin
				post_divide_select <= pwdata[`PMT_CTL_POST_HI:`PMT_CTL_POST_LO];
				timer_run          <= pwdata[`PMT_CTL_RUN];
				pre_divide_select  <= pwdata[`PMT_CTL_PRE_HI:`PMT_CTL_PRE_LO];
			end
			if (per_wr) begin
				period_value <= pwdata[7:0];
			end
			if (ena_wr) begin
				irq_enable <= pwdata[0];
			end
		end
	end

	// Instruction tick: oscillator divided by four, free running
	assign instr_if.tick = 1'b1;
	assign instr_if.clr  = 1'b0;
	assign instr_if.lim  = `PMT_INSTR_LIM;
	pmt_scaler u_instr (
		.clk   (clk),
		.rst_n (rst_n),
		.dv    (instr_if.div)
	);

	// Prescaler; a stopped timer gates its ticks off to save power
	wire scaler_clr = cnt_wr || ctl_wr;
	assign pre_if.tick = instr_if.pulse && timer_run;
	assign pre_if.clr  = scaler_clr;
	assign pre_if.lim  = pre_divide_select[1] ? `PMT_PRE16_LIM :
	                     pre_divide_select[0] ? `PMT_PRE4_LIM : `PMT_PRE1_LIM;
	pmt_scaler u_pre (
		.clk   (clk),
		.rst_n (rst_n),
		.dv    (pre_if.div)
	);

	// Match when the counter equals the period on a prescaled tick
	wire at_period   = (tick_count == period_value);
	wire match_pulse = pre_if.pulse && at_period;
	assign next_count = at_period ? 8'h00 : tick_count + 8'h01;

	// Counter; a software write wins over a tick in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tick_count <= `PMT_COUNT_RST;
		end else if (cnt_wr) begin
			tick_count <= pwdata[7:0];
		end else if (pre_if.pulse) begin
			tick_count <= next_count;
		end
	end

	// Postscaler divides matches by select plus one
	assign post_if.tick = match_pulse;
	assign post_if.clr  = scaler_clr;
	assign post_if.lim  = post_divide_select;
	pmt_scaler u_post (
		.clk   (clk),
		.rst_n (rst_n),
		.dv    (post_if.div)
	);

	// Sticky flag; a new event outranks a clear in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			match_flag <= 1'b0;
		end else if (post_if.pulse) begin
			match_flag <= 1'b1;
		end else if (clr_wr) begin
			match_flag <= 1'b0;
		end
	end

	assign irq = match_flag && irq_enable;

	// Time base for the capture/compare/PWM unit, one pulse per match
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pwm_time_base <= 1'b0;
		end else begin
			pwm_time_base <= match_pulse;
		end
	end

	// Checks
	property p_cnt_wr;
		@(posedge clk) disable iff (!rst_n)
		cnt_wr |=> (tick_count == $past(pwdata[7:0]));
	endproperty
	a_cnt_wr: assert property (p_cnt_wr) else $error("counter write not taken");

	property p_per_wr;
		@(posedge clk) disable iff (!rst_n)
		per_wr |=> (period_value == $past(pwdata[7:0]));
	endproperty
	a_per_wr: assert property (p_per_wr) else $error("period write not taken");

	property p_instr;
		@(posedge clk) disable iff (!rst_n)
		instr_if.pulse |=> !instr_if.pulse [*3] ##1 instr_if.pulse;
	endproperty
	a_instr: assert property (p_instr) else $error("instruction tick not every four clocks");

	property p_pre16;
		@(posedge clk) disable iff (!rst_n)
		(pre_if.pulse && pre_divide_select[1] && !ctl_wr) |=> !pre_if.pulse [*8];
	endproperty
	a_pre16: assert property (p_pre16) else $error("divide by sixteen pulsed early");

	property p_post;
		@(posedge clk) disable iff (!rst_n)
		post_if.pulse |-> (match_pulse && (post_if.cnt >= post_divide_select));
	endproperty
	a_post: assert property (p_post) else $error("postscaler pulse without due match");

	property p_stop;
		@(posedge clk) disable iff (!rst_n)
		(!timer_run && !cnt_wr) |=> $stable(tick_count);
	endproperty
	a_stop: assert property (p_stop) else $error("counter moved while stopped");

	property p_flag;
		@(posedge clk) disable iff (!rst_n)
		post_if.pulse |=> match_flag [*1] ##0 (irq == irq_enable);
	endproperty
	a_flag: assert property (p_flag) else $error("flag not set by match");

	property p_flag_hold;
		@(posedge clk) disable iff (!rst_n)
		(match_flag && !clr_wr) |=> match_flag;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear");

	property p_reset;
		@(posedge clk)
		!rst_n |=> (tick_count == 8'h00) && (pre_if.cnt == 4'h0) && (post_if.cnt == 4'h0);
	endproperty
	a_reset: assert property (p_reset) else $error("reset left timer state");

	property p_scl_clr;
		@(posedge clk) disable iff (!rst_n)
		scaler_clr |=> (pre_if.cnt == 4'h0) && (post_if.cnt == 4'h0);
	endproperty
	a_scl_clr: assert property (p_scl_clr) else $error("scalers not cleared by write");

	property p_ctl_keep;
		@(posedge clk) disable iff (!rst_n)
		(ctl_wr && !cnt_wr) |=> $stable(tick_count);
	endproperty
	a_ctl_keep: assert property (p_ctl_keep) else $error("control write changed counter");

	property p_bit7;
		@(posedge clk) disable iff (!rst_n)
		(setup_phase && !pwrite && hit_control) |=> (prdata[31:7] == 25'h0);
	endproperty
	a_bit7: assert property (p_bit7) else $error("control upper bits not zero");

	property p_pwm;
		@(posedge clk) disable iff (!rst_n)
		match_pulse |=> pwm_time_base ##1 !pwm_time_base;
	endproperty
	a_pwm: assert property (p_pwm) else $error("time base pulse wrong");

	property p_wrap;
		@(posedge clk) disable iff (!rst_n)
		(pre_if.pulse && at_period && !cnt_wr) |=> (tick_count == 8'h00);
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap at period");
endmodule : pmt_timer
